// ==== rtl/sdram_cmd_pkg.sv ====
/*
 * Shared constants for the memory-side command block: pin encodings,
 * mode field positions and codes, reset values and timing counts.
 * Assumes a single 200 MHz clock shared by all users.
 */
package sdram_cmd_pkg;

    // ------------------------------------------------------------
    // Command encodings on {ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    localparam logic [2:0] CMD_MODE_LOAD = 3'h0;
    localparam logic [2:0] CMD_REFRESH = 3'h1;
    localparam logic [2:0] CMD_BURST_STOP = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // ------------------------------------------------------------
    // Mode word layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int COL_W = 10;
    localparam int ROW_W = 13;
    localparam int BL_LSB = 0;
    localparam int BT_BIT = 3;
    localparam int CL_LSB = 4;
    localparam int TM_LSB = 7;
    localparam int WBM_BIT = 9;

    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [2:0] CL_3 = 3'h3;

    localparam logic [COL_W-1:0] MASK_1 = 10'h000;
    localparam logic [COL_W-1:0] MASK_2 = 10'h001;
    localparam logic [COL_W-1:0] MASK_4 = 10'h003;
    localparam logic [COL_W-1:0] MASK_8 = 10'h007;
    localparam logic [COL_W-1:0] MASK_PAGE = 10'h3FF;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [2:0] BL_RESET = 3'h0;
    localparam logic [2:0] CL_RESET = 3'h3;
    localparam int CLK_PERIOD_NS = 5;
    localparam int MRD_CYCLES = 2;
    localparam int T_REFI_NS = 7800;
    // Longest interval, so rounds down
    localparam int REFI_CYCLES = T_REFI_NS / CLK_PERIOD_NS;
    localparam int REFI_W = 11;
    localparam int RD_PIPE_W = 3;

    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_POWER_DOWN,
        ST_SELF_REFRESH
    } dev_state_t;

endpackage

// ==== rtl/burst_if.sv ====
/*
 * Carrier between the command block and its column generator.
 * Assumes both ends run on the same clock; the generator is pure logic.
 */
interface burst_if;
    logic [sdram_cmd_pkg::COL_W-1:0] start_col;
    logic [sdram_cmd_pkg::COL_W-1:0] beat;
    logic [sdram_cmd_pkg::COL_W-1:0] len_mask;
    logic interleave;
    logic [sdram_cmd_pkg::COL_W-1:0] col;

    modport ctrl (output start_col, output beat, output len_mask, output interleave, input col);
    modport gen (input start_col, input beat, input len_mask, input interleave, output col);
endinterface

// ==== rtl/burst_col_gen.sv ====
/*
 * Column address for one burst beat, sequential or interleaved.
 * Assumes len_mask covers the low bits of the aligned burst block.
 */
module burst_col_gen (
    burst_if.gen bus
);
    logic [sdram_cmd_pkg::COL_W-1:0] seq_sum;

    // Carries beyond the mask are dropped, which gives the wrap
    assign seq_sum = bus.start_col + bus.beat;

    genvar i;
    generate
        for (i = 0; i < sdram_cmd_pkg::COL_W; i++) begin : g_bit
            assign bus.col[i] = !bus.len_mask[i] ? bus.start_col[i] :
                                bus.interleave ? (bus.start_col[i] ^ bus.beat[i]) : seq_sum[i];
        end
    endgenerate
endmodule

// ==== rtl/sdram_mode_refresh_power_cmds.sv ====
/*
 * Memory-side command handling: mode load, no-operation, deselect,
 * burst stop, auto and self refresh, clock suspend and power-down.
 * Assumes command pins are sampled on ref_clk_i by a controller on the
 * same clock, and that bank logic elsewhere raises burst_start_i.
 */
module sdram_mode_refresh_power_cmds (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic cke_i,
    input wire logic [sdram_cmd_pkg::ADDR_W-1:0] addr_i,
    input wire logic [1:0] ba_i,
    input wire logic burst_start_i,
    input wire logic burst_write_i,
    input wire logic burst_auto_pre_i,
    input wire logic [sdram_cmd_pkg::COL_W-1:0] start_col_i,
    output logic [2:0] burst_len_code_o,
    output logic burst_order_select_o,
    output logic [2:0] cas_latency_o,
    output logic [1:0] test_mode_o,
    output logic write_burst_mode_bit_o,
    output logic mode_busy_o,
    output logic refresh_pulse_o,
    output logic [sdram_cmd_pkg::ROW_W-1:0] refresh_row_o,
    output logic self_refresh_o,
    output logic power_down_o,
    output logic clk_suspend_o,
    output logic burst_active_o,
    output logic [sdram_cmd_pkg::COL_W-1:0] burst_col_o,
    output logic read_drive_o
);
    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    sdram_cmd_pkg::dev_state_t state_q;
    logic cke_q;
    logic [2:0] cmd;
    logic cmd_ok;
    logic mode_load;
    logic auto_ref;
    logic sr_entry;
    logic stop_cmd;
    logic suspend;

    assign cmd = {ras_n_i, cas_n_i, we_n_i};
    // Deselect gates every decoded command, not power-down or bursts; nop simply matches no action
    assign cmd_ok = !cs_n_i && cke_q && (state_q == sdram_cmd_pkg::ST_ACTIVE);
    assign mode_load = cmd_ok && (cmd == sdram_cmd_pkg::CMD_MODE_LOAD);
    assign auto_ref = cmd_ok && cke_i && (cmd == sdram_cmd_pkg::CMD_REFRESH);
    assign sr_entry = cmd_ok && !cke_i && (cmd == sdram_cmd_pkg::CMD_REFRESH);
    assign stop_cmd = cmd_ok && (cmd == sdram_cmd_pkg::CMD_BURST_STOP);
    // Low enable at one edge masks the following edge
    assign suspend = !cke_q && burst_active_o;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cke_q <= 1'b0;
        end else begin
            cke_q <= cke_i;
        end
    end

    // ------------------------------------------------------------
    // Mode word
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            burst_len_code_o <= sdram_cmd_pkg::BL_RESET;
            burst_order_select_o <= 1'b0;
            cas_latency_o <= sdram_cmd_pkg::CL_RESET;
            test_mode_o <= 2'h0;
            write_burst_mode_bit_o <= 1'b0;
        end else if (mode_load) begin
            burst_len_code_o <= addr_i[sdram_cmd_pkg::BL_LSB +: 3];
            burst_order_select_o <= addr_i[sdram_cmd_pkg::BT_BIT];
            cas_latency_o <= addr_i[sdram_cmd_pkg::CL_LSB +: 3];
            test_mode_o <= addr_i[sdram_cmd_pkg::TM_LSB +: 2];
            write_burst_mode_bit_o <= addr_i[sdram_cmd_pkg::WBM_BIT];
        end
    end

    logic [1:0] mrd_cnt_q;
    logic [1:0] mrd_cnt_d;

    always_comb begin
        mrd_cnt_d = mrd_cnt_q;
        if (mode_load) begin
            mrd_cnt_d = 2'(sdram_cmd_pkg::MRD_CYCLES);
        end else if (mrd_cnt_q != 2'h0) begin
            mrd_cnt_d = mrd_cnt_q - 2'h1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mrd_cnt_q <= 2'h0;
            mode_busy_o <= 1'b0;
        end else begin
            mrd_cnt_q <= mrd_cnt_d;
            // High while the load interval counts down, both cycles of it
            mode_busy_o <= (mrd_cnt_d != 2'h0);
        end
    end

    // ------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= sdram_cmd_pkg::ST_ACTIVE;
        end else begin
            case (state_q)
                sdram_cmd_pkg::ST_ACTIVE: begin
                    if (sr_entry) begin
                        state_q <= sdram_cmd_pkg::ST_SELF_REFRESH;
                    end else if (cke_q && !cke_i && !burst_active_o && !burst_start_i) begin
                        state_q <= sdram_cmd_pkg::ST_POWER_DOWN;
                    end
                end
                sdram_cmd_pkg::ST_POWER_DOWN: begin
                    if (cke_i) begin
                        state_q <= sdram_cmd_pkg::ST_ACTIVE;
                    end
                end
                sdram_cmd_pkg::ST_SELF_REFRESH: begin
                    if (cke_i) begin
                        state_q <= sdram_cmd_pkg::ST_ACTIVE;
                    end
                end
                default: begin
                    state_q <= sdram_cmd_pkg::ST_ACTIVE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            self_refresh_o <= 1'b0;
            power_down_o <= 1'b0;
            clk_suspend_o <= 1'b0;
        end else begin
            self_refresh_o <= (state_q == sdram_cmd_pkg::ST_SELF_REFRESH) || sr_entry;
            power_down_o <= (state_q == sdram_cmd_pkg::ST_POWER_DOWN);
            clk_suspend_o <= !cke_i && (burst_active_o || burst_start_i);
        end
    end

    // ------------------------------------------------------------
    // Refresh row counter and self-refresh timer
    // ------------------------------------------------------------
    logic [sdram_cmd_pkg::REFI_W-1:0] refi_q;
    logic self_tick;

    // Self-timed interval only approximates the external average rate
    assign self_tick = (state_q == sdram_cmd_pkg::ST_SELF_REFRESH) &&
                       (refi_q == sdram_cmd_pkg::REFI_W'(sdram_cmd_pkg::REFI_CYCLES - 1));

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            refi_q <= '0;
        end else if (state_q != sdram_cmd_pkg::ST_SELF_REFRESH || self_tick) begin
            refi_q <= '0;
        end else begin
            refi_q <= refi_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            refresh_row_o <= '0;
            refresh_pulse_o <= 1'b0;
        end else begin
            refresh_pulse_o <= auto_ref || self_tick;
            if (auto_ref || self_tick) begin
                refresh_row_o <= refresh_row_o + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Burst sequencing
    // ------------------------------------------------------------
    logic [sdram_cmd_pkg::COL_W-1:0] beat_q;
    logic [sdram_cmd_pkg::COL_W-1:0] start_q;
    logic [sdram_cmd_pkg::COL_W-1:0] mask;
    logic wr_q;
    logic ap_q;
    logic single;
    logic page;
    logic last;
    burst_if bif ();

    always_comb begin
        case (burst_len_code_o)
            sdram_cmd_pkg::BL_2: mask = sdram_cmd_pkg::MASK_2;
            sdram_cmd_pkg::BL_4: mask = sdram_cmd_pkg::MASK_4;
            sdram_cmd_pkg::BL_8: mask = sdram_cmd_pkg::MASK_8;
            sdram_cmd_pkg::BL_PAGE: mask = sdram_cmd_pkg::MASK_PAGE;
            default: mask = sdram_cmd_pkg::MASK_1;
        endcase
    end

    assign page = (burst_len_code_o == sdram_cmd_pkg::BL_PAGE);
    assign single = wr_q && write_burst_mode_bit_o;
    // Page bursts have no natural end; only a stop, a new burst or a single-write beat ends them
    assign last = single || (!page && beat_q == mask);

    assign bif.start_col = start_q;
    assign bif.beat = beat_q;
    assign bif.len_mask = single ? sdram_cmd_pkg::MASK_1 : mask;
    assign bif.interleave = burst_order_select_o && !page;

    burst_col_gen u_col_gen (
        .bus(bif.gen)
    );

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            burst_active_o <= 1'b0;
            beat_q <= '0;
            start_q <= '0;
            wr_q <= 1'b0;
            ap_q <= 1'b0;
        end else if (burst_start_i && cke_q) begin
            burst_active_o <= 1'b1;
            beat_q <= '0;
            start_q <= start_col_i;
            wr_q <= burst_write_i;
            ap_q <= burst_auto_pre_i;
        end else if (stop_cmd && burst_active_o && !ap_q) begin
            burst_active_o <= 1'b0;
        end else if (burst_active_o && !suspend) begin
            if (last) begin
                burst_active_o <= 1'b0;
            end else begin
                beat_q <= beat_q + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            burst_col_o <= '0;
        end else if (!suspend) begin
            burst_col_o <= bif.col;
        end
    end

    // ------------------------------------------------------------
    // Read output pipeline
    // ------------------------------------------------------------
    logic [sdram_cmd_pkg::RD_PIPE_W-1:0] rd_pipe_q;
    logic rd_beat;

    // Beats already taken before a stop still drain through the latency
    assign rd_beat = burst_active_o && !wr_q && !(stop_cmd && !ap_q);

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_pipe_q <= '0;
            read_drive_o <= 1'b0;
        end else if (!suspend) begin
            rd_pipe_q <= {rd_pipe_q[sdram_cmd_pkg::RD_PIPE_W-2:0], rd_beat};
            read_drive_o <= (cas_latency_o == sdram_cmd_pkg::CL_2) ? rd_pipe_q[0] : rd_pipe_q[1];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_mode_load;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        mode_load |=> burst_len_code_o == $past(addr_i[2:0]) && cas_latency_o == $past(addr_i[6:4]);
    endproperty
    a_mode_load: assert property (p_mode_load) else $error("mode word not loaded");

    property p_mode_busy;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        mode_load |=> mode_busy_o [*2] ##1 (!mode_busy_o || $past(mode_load));
    endproperty
    a_mode_busy: assert property (p_mode_busy) else $error("mode busy not two cycles");

    property p_deselect;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        cs_n_i |=> $stable(burst_len_code_o) && !($past(auto_ref));
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselected cycle acted");

    property p_refresh_row;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        auto_ref |=> refresh_pulse_o && refresh_row_o == $past(refresh_row_o) + 1'b1;
    endproperty
    a_refresh_row: assert property (p_refresh_row) else $error("refresh row not advanced");

    property p_stop;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        stop_cmd && burst_active_o && !burst_start_i |=> burst_active_o == $past(ap_q);
    endproperty
    a_stop: assert property (p_stop) else $error("burst stop mishandled");

    property p_stop_drain;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        stop_cmd && burst_active_o && !ap_q && !wr_q && cke_i && cke_q |-> ##4 !read_drive_o;
    endproperty
    a_stop_drain: assert property (p_stop_drain) else $error("read output did not end after stop");

    property p_self_refresh;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        sr_entry |=> self_refresh_o;
    endproperty
    a_self_refresh: assert property (p_self_refresh) else $error("self refresh not entered");

    property p_suspend_hold;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        suspend && !burst_start_i && !stop_cmd |=> $stable(beat_q) && $stable(rd_pipe_q);
    endproperty
    a_suspend_hold: assert property (p_suspend_hold) else $error("suspended burst moved");

    property p_pd_exit;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        state_q == sdram_cmd_pkg::ST_POWER_DOWN && cke_i |=> state_q == sdram_cmd_pkg::ST_ACTIVE;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("power-down not left");

    property p_single_write;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        burst_start_i && cke_q && burst_write_i && write_burst_mode_bit_o && cke_i |=> ##1 !burst_active_o || $past(burst_start_i);
    endproperty
    a_single_write: assert property (p_single_write) else $error("single write ran long");
endmodule

// ==== tb/sdram_ctrl_model.sv ====
/*
 * Controller model: drives the command pins of the memory-side block.
 * Assumes its tasks are called just after a rising edge of ref_clk_i.
 */
module sdram_ctrl_model #(
    parameter int MRD_CYCLES = 2,
    parameter int RFC_CYCLES = 11,
    parameter int XSR_CYCLES = 12
) (
    input wire logic ref_clk_i,
    output logic cs_n_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output logic cke_o,
    output logic [sdram_cmd_pkg::ADDR_W-1:0] addr_o,
    output logic [1:0] ba_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    int cyc = 0;
    int ready_at = 0;

    always @(posedge ref_clk_i) cyc <= cyc + 1;

    initial begin
        {cs_n_o, ras_n_o, cas_n_o, we_n_o, cke_o} = 5'h1F;
        addr_o = 13'h0000;
        ba_o = 2'h0;
    end

    // Unselected lines flip so a stale value never passes for a real one
    task automatic release_pins();
        cs_n_o = 1'b1;
        {ras_n_o, cas_n_o, we_n_o} = ~{ras_n_o, cas_n_o, we_n_o};
        addr_o = ~addr_o;
        ba_o = ~ba_o;
    endtask

    // Caller keeps every bank idle around mode loads and refreshes
    task automatic issue(input logic cs_n, input logic [2:0] cmd, input logic [12:0] addr, input logic cke);
        while (cyc < ready_at) begin
            @(posedge ref_clk_i);
            #1;
        end
        if (!cke_o && cke) begin
            cke_o = 1'b1;
            @(posedge ref_clk_i);
            #1;
        end
        cs_n_o = cs_n;
        {ras_n_o, cas_n_o, we_n_o} = cmd;
        cke_o = cke;
        addr_o = addr;
        ba_o = 2'h0;
        if (cmd == sdram_cmd_pkg::CMD_MODE_LOAD) begin
            addr_o[12:10] = 3'h0;
            addr_o[8:7] = 2'h0;
        end
        @(posedge ref_clk_i);
        #1;
        release_pins();
        if (!cs_n && cmd == sdram_cmd_pkg::CMD_MODE_LOAD)
            ready_at = cyc + MRD_CYCLES - 1;
        // Short run: far fewer than 8192 refreshes are owed
        if (!cs_n && cmd == sdram_cmd_pkg::CMD_REFRESH && cke)
            ready_at = cyc + RFC_CYCLES - 1;
    endtask

    // Suspend and power-down are held only for a few clocks
    task automatic set_cke(input logic v);
        cke_o = v;
    endtask

    task automatic sref_exit();
        cke_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        ready_at = cyc + XSR_CYCLES - 1;
    endtask
endmodule

// ==== tb/test_sdram_mode_refresh_power_cmds.sv ====
/*
 * Bench for the command block: mode loads, deselect, refresh, bursts,
 * suspend, power-down and self refresh. Assumes one 200 MHz clock.
 */
module test_sdram_mode_refresh_power_cmds;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Clock, partner and block
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic cs_n, ras_n, cas_n, we_n, cke, bt, wbm, busy, rpulse, sref, pd, susp, bact, rdrv;
    logic [12:0] addr, row;
    logic [1:0] ba, tm;
    logic [2:0] bl, cl;
    logic [9:0] col;
    logic bstart = 1'b0, bwrite = 1'b0, bpre = 1'b0;
    logic [9:0] scol = 10'h000;
    logic [12:0] r0;
    logic [9:0] c0;
    logic [2:0] bls [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    int hits;
    int fails = 0;
    int compares = 0;

    always #2.5 ref_clk = ~ref_clk;

    sdram_ctrl_model u_ctrl (.ref_clk_i(ref_clk), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
        .we_n_o(we_n), .cke_o(cke), .addr_o(addr), .ba_o(ba));

    sdram_mode_refresh_power_cmds u_dut (.ref_clk_i(ref_clk), .resetn_i(resetn), .cs_n_i(cs_n),
        .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .cke_i(cke), .addr_i(addr), .ba_i(ba),
        .burst_start_i(bstart), .burst_write_i(bwrite), .burst_auto_pre_i(bpre), .start_col_i(scol),
        .burst_len_code_o(bl), .burst_order_select_o(bt), .cas_latency_o(cl), .test_mode_o(tm),
        .write_burst_mode_bit_o(wbm), .mode_busy_o(busy), .refresh_pulse_o(rpulse),
        .refresh_row_o(row), .self_refresh_o(sref), .power_down_o(pd), .clk_suspend_o(susp),
        .burst_active_o(bact), .burst_col_o(col), .read_drive_o(rdrv));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic mode_set(input logic [2:0] b, input logic o, input logic [2:0] c, input logic w);
        u_ctrl.issue(1'b0, sdram_cmd_pkg::CMD_MODE_LOAD, {3'h0, w, 2'h0, c, o, b}, 1'b1);
        chk({bl, bt, cl, tm, wbm}, {b, o, c, 2'h0, w});
        chk(busy, 1'b1);
        step();
        chk(busy, 1'b1);
        step();
        chk(busy, 1'b0);
    endtask

    task automatic start_burst(input logic [9:0] s, input logic w, input logic p);
        {bstart, bwrite, bpre, scol} = {1'b1, w, p, s};
        step();
        bstart = 1'b0;
    endtask

    task automatic check_burst(input logic [9:0] s, input int n, input logic [9:0] m, input logic il);
        logic [9:0] e;
        step();
        for (int i = 0; i < n; i++) begin
            e = (s & ~m) | ((il ? (s ^ 10'(i)) : (s + 10'(i))) & m);
            chk(col, e);
            step();
        end
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #40000;
        fails++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        #1 resetn = 1'b1;
        step();
        step();
        chk({bl, cl}, {sdram_cmd_pkg::BL_RESET, sdram_cmd_pkg::CL_RESET});
        chk({bt, tm, wbm, busy, rpulse, sref, pd, susp, bact, rdrv}, 11'h000);
        for (int i = 0; i < 5; i++)
            mode_set(bls[i], 1'b0, i[0] ? 3'h3 : 3'h2, i[1]);
        mode_set(3'h3, 1'b1, 3'h3, 1'b0);
        mode_set(3'h2, 1'b0, 3'h2, 1'b0);
        u_ctrl.issue(1'b1, sdram_cmd_pkg::CMD_MODE_LOAD, 13'h0033, 1'b1);
        chk({bl, busy}, {3'h2, 1'b0});
        u_ctrl.issue(1'b0, sdram_cmd_pkg::CMD_NOP, 13'h0033, 1'b1);
        chk({bl, busy, rpulse, bact}, {3'h2, 3'h0});
        for (int k = 0; k < 2; k++) begin
            r0 = row;
            hits = 0;
            u_ctrl.issue(1'b0, sdram_cmd_pkg::CMD_REFRESH, 13'h1555, 1'b1);
            repeat (3) begin
                if (rpulse === 1'b1) hits++;
                step();
            end
            chk(hits, 1);
            chk(row, r0 + 13'h0001);
            chk(bl, 3'h2);
        end
        start_burst(10'h001, 1'b0, 1'b0);
        check_burst(10'h001, 4, sdram_cmd_pkg::MASK_4, 1'b0);
        mode_set(3'h3, 1'b1, 3'h3, 1'b0);
        start_burst(10'h005, 1'b0, 1'b0);
        check_burst(10'h005, 8, sdram_cmd_pkg::MASK_8, 1'b1);
        mode_set(3'h7, 1'b0, 3'h3, 1'b0);
        start_burst(10'h3FE, 1'b0, 1'b0);
        check_burst(10'h3FE, 6, sdram_cmd_pkg::MASK_PAGE, 1'b0);
        u_ctrl.issue(1'b0, sdram_cmd_pkg::CMD_BURST_STOP, 13'h0000, 1'b1);
        step();
        chk({bact, rdrv}, 2'h1);
        repeat (4) step();
        chk(rdrv, 1'b0);
        mode_set(3'h3, 1'b0, 3'h3, 1'b0);
        start_burst(10'h000, 1'b0, 1'b1);
        u_ctrl.issue(1'b0, sdram_cmd_pkg::CMD_BURST_STOP, 13'h0000, 1'b1);
        step();
        chk(bact, 1'b1);
        repeat (10) step();
        mode_set(3'h2, 1'b0, 3'h2, 1'b1);
        start_burst(10'h000, 1'b1, 1'b0);
        chk(bact, 1'b1);
        step();
        chk(bact, 1'b0);
        mode_set(3'h7, 1'b0, 3'h3, 1'b0);
        start_burst(10'h000, 1'b0, 1'b0);
        repeat (3) step();
        u_ctrl.set_cke(1'b0);
        repeat (2) step();
        chk(susp, 1'b1);
        c0 = col;
        repeat (2) step();
        chk(col, c0);
        u_ctrl.set_cke(1'b1);
        repeat (3) step();
        chk({susp, col !== c0}, 2'h1);
        u_ctrl.issue(1'b0, sdram_cmd_pkg::CMD_BURST_STOP, 13'h0000, 1'b1);
        repeat (8) step();
        chk({bact, rdrv}, 2'h0);
        u_ctrl.set_cke(1'b0);
        repeat (2) step();
        chk(pd, 1'b1);
        u_ctrl.set_cke(1'b1);
        repeat (3) step();
        chk(pd, 1'b0);
        u_ctrl.issue(1'b0, sdram_cmd_pkg::CMD_REFRESH, 13'h0000, 1'b0);
        repeat (2) step();
        chk(sref, 1'b1);
        u_ctrl.issue(1'b0, sdram_cmd_pkg::CMD_MODE_LOAD, 13'h0022, 1'b0);
        chk(bl, 3'h7);
        hits = 0;
        repeat (1600) begin
            if (rpulse === 1'b1) hits++;
            step();
        end
        chk(hits == 1 || hits == 2, 1'b1);
        u_ctrl.sref_exit();
        repeat (3) step();
        chk(sref, 1'b0);
        test_done();
    end
endmodule
